// ==== design/spb_defines.svh ====
// constants for the serial peripheral bridge
// Functional notes
// R1: track word sync, mark first/last bit
// R2: select instruction enters bridge mode
// R3: bridge instructions act only in mode
// R4: odd bridge instruction leaves bridge mode
// R5: select code is a build-time option
// R6: load copies register C, sets busy
// R7: save drives buffer 2, clears read-ready
// R8: CPU follows save with odd instruction
// R9: flag test puts chosen flag in carry
// R10: busy holds until buffer 1 sent
// R11: peripheral-on flag follows peripheral state
// R12: power-ok rise clears all internal state; the control bit wake_en_r keeps its value
// R13: strobes then direction rise set read-ready
// R14: two strobes then direction fall clear busy
// R15: send print flag, read-ready, 56 bits
// R16: shift 56 inbound bits into buffer 2
// R17: light-sleep wake drives instruction line high
// R18: wake instruction pulls power-on low one word
// R19: peripheral holds data two clocks after strobe
// R20: flag one clock, bits two clocks later
// R21: peripheral sets data before strobe rises
// R22: two independent 56-bit buffers
// R23: buffers move least significant bit first
`ifndef SPB_DEFINES_SVH
`define SPB_DEFINES_SVH
`define SPB_WORD_BITS    56
`define SPB_LAST_BIT     6'h37
`define SPB_INSTR_BITS   10
`define SPB_SEL_CODE     10'h264
`define SPB_SEL_CODE_2ND 10'h224
`define SPB_LOAD_LOW3    3'h7
`define SPB_WAKE_LOW3    3'h1
`define SPB_SAVE_LOW6    6'h3a
`define SPB_FLAG_LOW6    6'h03
`define SPB_FLAG_BUSY    3'h0
`define SPB_FLAG_READY   3'h1
`define SPB_FLAG_PON     3'h2
`define SPB_CLK_NS       100
`define SPB_SLEEP_NS     10000
`define SPB_SLEEP_CYC    ((`SPB_SLEEP_NS + `SPB_CLK_NS - 1) / `SPB_CLK_NS)
`define SPB_OUT_LAST     6'h39
`define SPB_ADDR_STATUS  8'h00
`define SPB_ADDR_CTRL    8'h04
`define SPB_ADDR_SELCODE 8'h08
`define SPB_CTRL_RESET   1'h1
`endif

// ==== design/spb_pkg.sv ====
// types for the serial peripheral bridge
package spb_pkg;
  // pending work for the word after an instruction
  typedef enum logic [1:0] {OP_NONE, OP_LOAD, OP_SAVE, OP_WAKE} spb_op_t;
  // inputs from the calculator side
  typedef struct packed {
    logic clk_ph;
    logic sync;
    logic instr_addr_line;
    logic data;
    logic power_ok;
  } spb_cpu_in_t;
  // inputs from the peripheral side
  typedef struct packed {
    logic strobe;
    logic direction;
    logic data;
    logic on_flag;
    logic power_on;
  } spb_periph_in_t;
endpackage

// ==== design/spb_bridge.sv ====
// serial peripheral bridge: cpu bus, peripheral link and ahb-lite status port
//
// Design decisions made here: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_bridge #(
  parameter logic [9:0] SEL_CODE = `SPB_SEL_CODE
) (
  input  wire  logic                hclk,
  input  wire  logic                hresetn,
  input  wire  logic                hsel,
  input  wire  logic [31:0]         haddr,
  input  wire  logic [1:0]          htrans,
  input  wire  logic                hwrite,
  input  wire  logic [2:0]          hsize,
  input  wire  logic [31:0]         hwdata,
  input  wire  logic                hready,
  output logic       [31:0]         hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire  spb_pkg::spb_cpu_in_t    cpu_in,
  input  wire  spb_pkg::spb_periph_in_t periph_in,
  output logic                      isa_o,
  output logic                      isa_oe,
  output logic                      cpu_data_o,
  output logic                      cpu_data_oe,
  output logic                      cpu_carry,
  output logic                      periph_data_o,
  output logic                      periph_data_oe,
  output logic                      power_on_o,
  output logic                      power_on_oe
);
  import spb_pkg::*;

  localparam int SLEEP_CYC = `SPB_SLEEP_CYC;

  // ****************************************
  // input synchronisers and edges
  // ****************************************
  spb_cpu_in_t    cpu_s1_r, cpu_s2_r, cpu_s3_r;
  spb_periph_in_t per_s1_r, per_s2_r, per_s3_r;

  // two flops per outside input, third copy for edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_s1_r <= '0;
      cpu_s2_r <= '0;
      cpu_s3_r <= '0;
      per_s1_r <= '0;
      per_s2_r <= '0;
      per_s3_r <= '0;
    end else begin
      cpu_s1_r <= cpu_in;
      cpu_s2_r <= cpu_s1_r;
      cpu_s3_r <= cpu_s2_r;
      per_s1_r <= periph_in;
      per_s2_r <= per_s1_r;
      per_s3_r <= per_s2_r;
    end
  end

  logic cpu_edge, pwo_rise, dir_rise, dir_fall, strb_rise;
  assign cpu_edge  = cpu_s2_r.clk_ph & ~cpu_s3_r.clk_ph;
  assign pwo_rise  = cpu_s2_r.power_ok & ~cpu_s3_r.power_ok;
  assign dir_rise  = per_s2_r.direction & ~per_s3_r.direction;
  assign dir_fall  = ~per_s2_r.direction & per_s3_r.direction;
  assign strb_rise = per_s2_r.strobe & ~per_s3_r.strobe;

  // ****************************************
  // word timing and instruction capture
  // ****************************************
  logic [5:0] bit_cnt_r;
  logic [9:0] instr_r;
  logic       sync_prev_r;
  logic       first_bit_time, last_bit_time, decode_now;

  assign first_bit_time = (bit_cnt_r == 6'h00);
  assign last_bit_time  = (bit_cnt_r == `SPB_LAST_BIT);
  // instruction is complete on the edge where sync has just dropped
  assign decode_now     = cpu_edge & sync_prev_r & ~cpu_s2_r.sync;

  // bit counter realigned by the end of the instruction field
  // count names the bit taken at the coming cpu edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bit_cnt_r   <= 6'h00;
      sync_prev_r <= 1'b0;
      instr_r     <= 10'h000;
    end else if (pwo_rise) begin
      bit_cnt_r   <= 6'h00;
      sync_prev_r <= 1'b0;
      instr_r     <= 10'h000;
    end else if (cpu_edge) begin
      sync_prev_r <= cpu_s2_r.sync;
      if (decode_now)
        bit_cnt_r <= 6'h00; // R1
      else if (last_bit_time)
        bit_cnt_r <= 6'h00; // R1
      else
        bit_cnt_r <= bit_cnt_r + 6'h01;
      if (cpu_s2_r.sync)
        instr_r <= {cpu_s2_r.instr_addr_line, instr_r[9:1]};
    end
  end

  // ****************************************
  // instruction decoder and mode
  // ****************************************
  logic    mode_r;
  spb_op_t op_r;
  logic    busy_r, ready_r, carry_r;
  logic    is_load, is_save, is_flag, is_wake;

  assign is_load = (instr_r[2:0] == `SPB_LOAD_LOW3);
  assign is_save = (instr_r[5:0] == `SPB_SAVE_LOW6);
  assign is_flag = (instr_r[5:0] == `SPB_FLAG_LOW6);
  assign is_wake = (instr_r[2:0] == `SPB_WAKE_LOW3);

  // mode entry on own select code, exit on any odd code
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= 1'b0;
    end else if (pwo_rise) begin
      mode_r <= 1'b0; // R12
    end else if (decode_now) begin
      if (!mode_r && instr_r == SEL_CODE)
        mode_r <= 1'b1; // R2 R5
      else if (mode_r && instr_r[0])
        mode_r <= 1'b0; // R4
    end
  end

  // pending operation runs through the following word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_r <= OP_NONE;
    end else if (pwo_rise) begin
      op_r <= OP_NONE;
    end else if (decode_now) begin
      if (!mode_r)
        op_r <= OP_NONE; // R3
      else if (is_load)
        op_r <= OP_LOAD;
      else if (is_save)
        op_r <= OP_SAVE;
      else if (is_wake)
        op_r <= OP_WAKE;
      else
        op_r <= OP_NONE;
    end else if (cpu_edge && last_bit_time) begin
      op_r <= OP_NONE;
    end
  end

  // flag test answers into the carry
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carry_r <= 1'b0;
    end else if (pwo_rise) begin
      carry_r <= 1'b0;
    end else if (decode_now && mode_r && is_flag) begin
      case (instr_r[8:6]) // R9
        `SPB_FLAG_BUSY:  carry_r <= busy_r;
        `SPB_FLAG_READY: carry_r <= ready_r;
        `SPB_FLAG_PON:   carry_r <= per_s2_r.on_flag; // R11
        default:         carry_r <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // buffers and cpu data transfer
  // ****************************************
  logic [`SPB_WORD_BITS-1:0] buf1_r, buf2_r; // R22
  logic                      cpu_dout_r, cpu_doe_r;
  logic                      op_end;

  // a word's operation ends at its last bit, even when that edge decodes the next one
  assign op_end = cpu_edge & last_bit_time;

  // load shifts register C in, least significant bit first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      buf1_r <= '0;
    else if (pwo_rise)
      buf1_r <= '0;
    else if (cpu_edge && op_r == OP_LOAD)
      buf1_r <= {cpu_s2_r.data, buf1_r[`SPB_WORD_BITS-1:1]}; // R6 R23
  end

  // save drives buffer 2 onto the data line for one word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_dout_r <= 1'b0;
      cpu_doe_r  <= 1'b0;
    end else if (pwo_rise) begin
      cpu_dout_r <= 1'b0;
      cpu_doe_r  <= 1'b0;
    end else if (cpu_edge) begin
      cpu_doe_r  <= (decode_now && mode_r && is_save) ||
                    (op_r == OP_SAVE && !last_bit_time); // R7
      if (decode_now)
        cpu_dout_r <= buf2_r[0];
      else if (op_r == OP_SAVE && !last_bit_time)
        cpu_dout_r <= buf2_r[bit_cnt_r + 6'h01]; // R23
    end
  end

  // ****************************************
  // peripheral link
  // ****************************************
  logic [5:0] out_idx_r;
  logic [1:0] out_wait_r;
  logic [6:0] out_strb_r, in_strb_r;
  logic       pdout_r, pdoe_r;

  // strobe counters per direction
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_strb_r  <= 7'h00;
      out_strb_r <= 7'h00;
    end else if (pwo_rise || dir_rise || dir_fall) begin
      in_strb_r  <= 7'h00;
      out_strb_r <= 7'h00;
    end else if (strb_rise) begin
      if (per_s2_r.direction)
        out_strb_r <= (out_strb_r == 7'h7f) ? out_strb_r : out_strb_r + 7'h01;
      else
        in_strb_r  <= (in_strb_r == 7'h7f) ? in_strb_r : in_strb_r + 7'h01;
    end
  end

  // inbound bits shift into buffer 2, lsb first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      buf2_r <= '0;
    else if (pwo_rise)
      buf2_r <= '0;
    else if (strb_rise && !per_s2_r.direction)
      buf2_r <= {per_s2_r.data, buf2_r[`SPB_WORD_BITS-1:1]}; // R16 R19 R21
  end

  // outbound pointer: 0 print flag, 1 read-ready, then buffer 1
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_idx_r  <= 6'h00;
      out_wait_r <= 2'h0;
    end else if (pwo_rise) begin
      out_idx_r  <= 6'h00;
      out_wait_r <= 2'h0;
    end else if (dir_rise) begin
      out_idx_r  <= 6'h00;
      out_wait_r <= 2'h1; // R20
    end else if (strb_rise && per_s2_r.direction) begin
      out_idx_r  <= (out_idx_r == `SPB_OUT_LAST) ? out_idx_r : out_idx_r + 6'h01;
      out_wait_r <= 2'h2; // R20
    end else if (cpu_edge && out_wait_r != 2'h0) begin
      out_wait_r <= out_wait_r - 2'h1;
    end
  end

  // data line output, updated after the system-clock delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pdout_r <= 1'b1;
      pdoe_r  <= 1'b0;
    end else if (pwo_rise) begin
      pdout_r <= 1'b1;
      pdoe_r  <= 1'b0;
    end else begin
      pdoe_r <= per_s2_r.direction; // R15
      if (cpu_edge && out_wait_r == 2'h1) begin
        if (out_idx_r == 6'h00)
          pdout_r <= busy_r; // R15
        else if (out_idx_r == 6'h01)
          pdout_r <= ready_r; // R15
        else
          pdout_r <= buf1_r[out_idx_r - 6'h02]; // R15 R23
      end
    end
  end

  // busy: load sets, finished outbound transfer clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      busy_r <= 1'b0;
    else if (pwo_rise)
      busy_r <= 1'b0; // R12
    else if (op_end && op_r == OP_LOAD)
      busy_r <= 1'b1; // R6 R10
    else if (dir_fall && out_strb_r >= 7'h02)
      busy_r <= 1'b0; // R14 R10
  end

  // read-ready: inbound word sets, save clears, set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ready_r <= 1'b0;
    else if (pwo_rise)
      ready_r <= 1'b0; // R12
    else if (dir_rise && in_strb_r >= 7'h01)
      ready_r <= 1'b1; // R13
    else if (op_end && op_r == OP_SAVE)
      ready_r <= 1'b0; // R7
  end

  // ****************************************
  // power-on line and light-sleep wake
  // ****************************************
  logic [6:0] idle_cnt_r;
  logic       sleep_r, isa_drv_r, pon_oe_r, wake_en_r;

  // light sleep: sync high and no cpu clock edge for a while
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idle_cnt_r <= 7'h00;
      sleep_r    <= 1'b0;
    end else if (cpu_edge || !cpu_s2_r.sync || pwo_rise) begin
      idle_cnt_r <= 7'h00;
      sleep_r    <= 1'b0;
    end else if (idle_cnt_r == 7'(SLEEP_CYC - 1)) begin
      sleep_r    <= 1'b1;
    end else begin
      idle_cnt_r <= idle_cnt_r + 7'h01;
    end
  end

  // peripheral wake request holds the instruction line high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      isa_drv_r <= 1'b0;
    else if (pwo_rise)
      isa_drv_r <= 1'b0; // R17
    else if (sleep_r && !per_s2_r.power_on && wake_en_r)
      isa_drv_r <= 1'b1; // R17
  end

  // wake instruction pulls power-on low for one word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      pon_oe_r <= 1'b0;
    else if (pwo_rise)
      pon_oe_r <= 1'b0;
    else if (cpu_edge && decode_now)
      pon_oe_r <= mode_r && is_wake && !is_load; // R18
    else if (op_end)
      pon_oe_r <= 1'b0; // R18
  end

  // ****************************************
  // ahb-lite slave
  // ****************************************
  logic        wr_pend_r;
  logic [7:0]  wr_addr_r;
  logic [31:0] rdata_r;
  logic        accept;

  assign accept = hsel & htrans[1] & hready;

  // address phase: latch write target, prepare read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0000_0000;
    end else begin
      wr_pend_r <= accept & hwrite;
      if (accept)
        wr_addr_r <= haddr[7:0];
      if (accept && !hwrite) begin
        case (haddr[7:0])
          `SPB_ADDR_STATUS:
            rdata_r <= {26'h0, isa_drv_r, sleep_r, mode_r,
                        per_s2_r.on_flag, ready_r, busy_r};
          `SPB_ADDR_CTRL:    rdata_r <= {31'h0, wake_en_r};
          `SPB_ADDR_SELCODE: rdata_r <= {22'h0, SEL_CODE};
          default:           rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // data phase write to the control word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      wake_en_r <= `SPB_CTRL_RESET;
    else if (wr_pend_r && wr_addr_r == `SPB_ADDR_CTRL)
      wake_en_r <= hwdata[0];
  end

  // ready from the first clock after reset, always okay, all from flops
  logic ready_out_r, resp_r, pon_o_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_out_r <= 1'b0;
      resp_r      <= 1'b0;
      pon_o_r     <= 1'b0;
    end else begin
      ready_out_r <= 1'b1;
      resp_r      <= 1'b0;
      pon_o_r     <= 1'b0;
    end
  end

  assign hrdata         = rdata_r;
  assign hreadyout      = ready_out_r;
  assign hresp          = resp_r;
  assign isa_o          = isa_drv_r;
  assign isa_oe         = isa_drv_r;
  assign cpu_data_o     = cpu_dout_r;
  assign cpu_data_oe    = cpu_doe_r;
  assign cpu_carry      = carry_r;
  assign periph_data_o  = pdout_r;
  assign periph_data_oe = pdoe_r;
  assign power_on_o     = pon_o_r;
  assign power_on_oe    = pon_oe_r;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_dir_up;
    dir_rise && !pwo_rise;
  endsequence

  property p_word_wrap;
    @(posedge hclk) disable iff (!hresetn)
      (cpu_edge && last_bit_time && !decode_now && !pwo_rise) |=> first_bit_time;
  endproperty
  a_word_wrap: assert property (p_word_wrap) else $error("word counter did not wrap"); // R1

  property p_mode_enter;
    @(posedge hclk) disable iff (!hresetn)
      (decode_now && !mode_r && instr_r == SEL_CODE && !pwo_rise) |=> mode_r;
  endproperty
  a_mode_enter: assert property (p_mode_enter) else $error("select missed"); // R2

  property p_ignore_outside;
    @(posedge hclk) disable iff (!hresetn)
      (decode_now && !mode_r) |=> (op_r == OP_NONE) ##1 ((op_r == OP_NONE) && $stable(busy_r));
  endproperty
  a_ignore_outside: assert property (p_ignore_outside) else $error("op outside mode"); // R3

  property p_odd_exit;
    @(posedge hclk) disable iff (!hresetn)
      (decode_now && mode_r && instr_r[0]) |=> !mode_r;
  endproperty
  a_odd_exit: assert property (p_odd_exit) else $error("odd code kept mode"); // R4

  property p_load_busy;
    @(posedge hclk) disable iff (!hresetn)
      (op_end && op_r == OP_LOAD && !pwo_rise) |=> busy_r;
  endproperty
  a_load_busy: assert property (p_load_busy) else $error("load left busy clear"); // R6

  property p_save_clear;
    @(posedge hclk) disable iff (!hresetn)
      (op_end && op_r == OP_SAVE && !dir_rise) |=> !ready_r;
  endproperty
  a_save_clear: assert property (p_save_clear) else $error("save kept read-ready"); // R7

  property p_carry_busy;
    @(posedge hclk) disable iff (!hresetn)
      (decode_now && mode_r && is_flag && instr_r[8:6] == 3'h0 && !pwo_rise)
        |=> (cpu_carry == $past(busy_r));
  endproperty
  a_carry_busy: assert property (p_carry_busy) else $error("carry not busy"); // R9

  property p_ready_set;
    @(posedge hclk) disable iff (!hresetn)
      (s_dir_up ##0 (in_strb_r >= 7'h01)) |=> ready_r;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("read-ready not set"); // R13

  property p_busy_clear;
    @(posedge hclk) disable iff (!hresetn)
      (dir_fall && out_strb_r >= 7'h02 && !op_end) |=> !busy_r;
  endproperty
  a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared"); // R14

  property p_out_enable;
    @(posedge hclk) disable iff (!hresetn)
      s_dir_up |=> ##1 periph_data_oe;
  endproperty
  a_out_enable: assert property (p_out_enable) else $error("data line not driven"); // R15

  property p_wake_isa;
    @(posedge hclk) disable iff (!hresetn)
      (sleep_r && !per_s2_r.power_on && wake_en_r && !pwo_rise) |=> isa_oe && isa_o;
  endproperty
  a_wake_isa: assert property (p_wake_isa) else $error("wake not driven"); // R17

  property p_pon_word;
    @(posedge hclk) disable iff (!hresetn)
      $rose(power_on_oe) |-> (op_r == OP_WAKE) && !power_on_o;
  endproperty
  a_pon_word: assert property (p_pon_word) else $error("power-on pulse wrong"); // R18
endmodule

// ==== dv/spb_periph_model.sv ====
// peripheral side model: strobes one word in and one word out of the bridge
`timescale 1ns/1ps
module spb_periph_model (
  input  wire logic hclk,
  input  wire logic dd_level,
  output logic      strobe,
  output logic      direction,
  output logic      data_o,
  output logic      data_oe
);
  // idle: line released to the pull-up, strobe and direction low
  initial begin
    strobe    = 1'b0;
    direction = 1'b0;
    data_o    = 1'b0;
    data_oe   = 1'b0;
  end
  // send w inward, turn the line round, read flags and buffer 1 back
  task automatic exchange(input logic [55:0] w, output logic [57:0] r);
    for (int k = 0; k < 56; k++) begin
      @(posedge hclk);
      data_o  <= w[k];
      data_oe <= 1'b1;
      repeat (2) @(posedge hclk);
      strobe <= 1'b1;
      repeat (12) @(posedge hclk);
      strobe <= 1'b0;
      repeat (6) @(posedge hclk);
    end
    data_oe <= 1'b0;
    repeat (2) @(posedge hclk);
    direction <= 1'b1;
    repeat (14) @(posedge hclk);
    r[0] = dd_level;
    for (int k = 1; k < 58; k++) begin
      strobe <= 1'b1;
      repeat (10) @(posedge hclk);
      strobe <= 1'b0;
      repeat (14) @(posedge hclk);
      r[k] = dd_level;
    end
    direction <= 1'b0;
  endtask
endmodule

// ==== dv/spb_bridge_tb.sv ====
// testbench for the serial peripheral bridge
`timescale 1ns/1ps
`include "spb_defines.svh"
module spb_bridge_tb;
  import spb_pkg::*;
  localparam logic [55:0] W1  = 56'h8d2f00ff1357a1;
  localparam logic [55:0] W2  = 56'h5ac30fe17b2496;
  localparam logic [9:0]  SEL = `SPB_SEL_CODE;
  logic           hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]    haddr, hwdata, hrdata;
  logic [1:0]     htrans;
  logic           isa_o, isa_oe, cpu_data_o, cpu_data_oe, cpu_carry;
  logic           periph_data_o, periph_data_oe, power_on_o, power_on_oe;
  logic [2:0]     ph_cnt = 3'h0;
  logic           ph_run, pon_pull;
  logic           sync, instr_addr_line, cdata, pok, on_flag;
  logic           pm_strobe, pm_dir, pm_d, pm_oe, dd_level;
  logic [55:0]    cap_d, cap_p;
  logic [57:0]    got;
  logic [12:0]    ft [5];
  int             failures, samples_checked;
  int             cycles = 0;
  spb_cpu_in_t    cpu_in;
  spb_periph_in_t periph_in;
  // ************************************************
  // wires: pull-up on the data line, link clock from hclk
  // ************************************************
  assign dd_level  = periph_data_oe ? periph_data_o : (pm_oe ? pm_d : 1'b1);
  // ph_run low stops the cpu clock for light sleep
  assign cpu_in    = '{clk_ph: ph_cnt[2] & ph_run, sync: sync, instr_addr_line: isa_oe ? isa_o : instr_addr_line,
                       data: cpu_data_oe ? cpu_data_o : cdata, power_ok: pok};
  assign periph_in = '{strobe: pm_strobe, direction: pm_dir, data: dd_level,
                       on_flag: on_flag, power_on: ~(power_on_oe | pon_pull)};
  spb_bridge uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_in(cpu_in),
    .periph_in(periph_in), .isa_o(isa_o), .isa_oe(isa_oe), .cpu_data_o(cpu_data_o),
    .cpu_data_oe(cpu_data_oe), .cpu_carry(cpu_carry), .periph_data_o(periph_data_o),
    .periph_data_oe(periph_data_oe), .power_on_o(power_on_o), .power_on_oe(power_on_oe));
  spb_periph_model pm (.hclk(hclk), .dd_level(dd_level), .strobe(pm_strobe),
    .direction(pm_dir), .data_o(pm_d), .data_oe(pm_oe));
  // clock, link phase counter, hang guard
  initial hclk = 1'b0;
  always #50 hclk = ~hclk;
  always @(posedge hclk) begin
    ph_cnt <= ph_cnt + 3'h1;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one single ahb transfer, read data taken at the data phase edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, e);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) chk({32'h0, hrdata}, {32'h0, e});
  endtask
  // one cpu word: instruction in bits 45..54 under sync, data lsb first
  task automatic cpu_word(input logic [9:0] ins, input logic [55:0] d);
    logic [55:0] iw, sw;
    iw = {1'b0, ins, 45'h0};
    sw = {1'b0, 10'h3ff, 45'h0};
    for (int b = 0; b < 56; b++) begin
      @(posedge hclk iff ph_cnt == 3'h7);
      sync  <= sw[b];
      instr_addr_line   <= iw[b];
      cdata <= d[b];
      @(posedge hclk iff ph_cnt == 3'h3);
      cap_d[b] = cpu_data_o;
      cap_p[b] = power_on_oe;
    end
    repeat (3) @(posedge hclk); // next call starts on the very next bit
  endtask
  task automatic report_and_stop();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {sync, instr_addr_line, cdata, on_flag, pon_pull} = '0;
    ph_run = 1'b1;
    pok = 1'b1;
    failures = 0;
    samples_checked = 0;
    ft = '{13'h1403, 13'h1043, 13'h0003, 13'h1c83, 13'h1083};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, 32'h0);
    ahb(1'b0, 8'h04, 32'h0, 32'h1);
    ahb(1'b0, 8'h08, 32'h0, {22'h0, SEL});
    ahb(1'b0, 8'h0c, 32'h0, 32'h0);
    ahb(1'b1, 8'h04, 32'h0, 32'h0);
    ahb(1'b0, 8'h04, 32'h0, 32'h0);
    ahb(1'b1, 8'h04, 32'h1, 32'h0);
    cpu_word(10'h224, 56'h0);
    cpu_word(10'h007, 56'h0);
    cpu_word(10'h000, W1);
    ahb(1'b0, 8'h00, 32'h0, 32'h0);
    cpu_word(SEL, 56'h0);
    ahb(1'b0, 8'h00, 32'h0, 32'h08);
    cpu_word(10'h007, 56'h0);
    cpu_word(10'h000, W1);
    ahb(1'b0, 8'h00, 32'h0, 32'h01);
    // flag tests: select, peripheral on, expected carry, code
    foreach (ft[i]) begin
      on_flag <= ft[i][11];
      if (ft[i][12]) cpu_word(SEL, 56'h0);
      cpu_word(ft[i][9:0], 56'h0);
      repeat (2) @(posedge hclk);
      chk(cpu_carry, ft[i][10]);
    end
    pm.exchange(W2, got);
    chk(got, {W1, 2'b11});
    repeat (20) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, 32'h02);
    cpu_word(SEL, 56'h0);
    ahb(1'b0, 8'h00, 32'h0, 32'h0a);
    cpu_word(10'h03a, 56'h0);
    cpu_word(10'h005, 56'h0);
    chk(cap_d, W2);
    ahb(1'b0, 8'h00, 32'h0, 32'h00);
    cpu_word(SEL, 56'h0);
    cpu_word(10'h001, 56'h0);
    cpu_word(10'h000, 56'h0);
    chk(cap_p, {56{1'b1}});
    repeat (2) @(posedge hclk);
    chk(power_on_oe, 1'b0);
    cpu_word(SEL, 56'h0);
    cpu_word(10'h007, 56'h0);
    cpu_word(10'h000, W1);
    ahb(1'b0, 8'h00, 32'h0, 32'h01);
    // light sleep: sync high, clock stopped, peripheral pulls power-on low
    sync     <= 1'b1;
    ph_run   <= 1'b0;
    pon_pull <= 1'b1;
    repeat (120) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, 32'h31);
    chk(isa_oe & isa_o, 1'b1);
    pok <= 1'b0;
    repeat (8) @(posedge hclk);
    pok      <= 1'b1;
    sync     <= 1'b0;
    ph_run   <= 1'b1;
    pon_pull <= 1'b0;
    repeat (8) @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0, 32'h00);
    ahb(1'b0, 8'h04, 32'h0, 32'h01);
    chk(isa_oe, 1'b0);
    report_and_stop();
  end
endmodule
